// ---- hw/rrmbc_pkg.sv ----
package rrmbc_pkg;

    // ----------------------------------------------------------------
    // clocking and rates
    // ----------------------------------------------------------------
    localparam int CLK_KHZ = 100000;
    localparam int CTRL_KHZ = 22008;
    localparam int ACC_W = 17;

    // ----------------------------------------------------------------
    // refresh timing
    // ----------------------------------------------------------------
    // retention is assumed; 128 rows must all be hit within it
    localparam int RETENTION_NS = 2000000;
    localparam int ROWS = 128;
    localparam int REFRESH_NS = RETENTION_NS / ROWS;
    // longest interval, so round down
    localparam int REFRESH_CYCLES_RAW = (REFRESH_NS * (CLK_KHZ / 1000)) / 1000;
    localparam int REFRESH_CYCLES =
        (REFRESH_CYCLES_RAW < 1) ? 1 : REFRESH_CYCLES_RAW;
    localparam int REF_W = 16;

    // ----------------------------------------------------------------
    // address layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int RA_W = 7;
    localparam int ROW_LSB = 1;
    localparam int COL_LSB = 8;
    localparam int SEL_MSB = 19;
    localparam int SEL_LSB = 15;
    localparam int BANK_LSB = 13;
    localparam int BANK_W = 3;
    localparam int BANKS = 8;
    localparam int WORD_LSB = 1;
    localparam int WORD_W = 12;
    localparam int BYTE_BIT = 0;
    localparam logic [4:0] RAM_SEL = 5'h00;
    localparam logic [4:0] ROM_SEL_A = 5'h1D;
    localparam logic [4:0] ROM_SEL_B = 5'h1E;
    localparam logic [ADDR_W-1:0] ROM_LO = 20'hE8000;
    localparam logic [ADDR_W-1:0] ROM_HI = 20'hF7FFF;

    // ----------------------------------------------------------------
    // controller states, gray from idle through xack
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ROW  = 3'h1,
        ST_RAS  = 3'h3,
        ST_COL  = 3'h2,
        ST_WE   = 3'h6,
        ST_CAS  = 3'h7,
        ST_XACK = 3'h5,
        ST_REF  = 3'h4
    } rrmbc_state_t;

endpackage

// ---- hw/rrmbc_ctrl.sv ----
`timescale 1ns/1ps
module rrmbc_ctrl #(
    parameter int REFRESH_CYC = rrmbc_pkg::REFRESH_CYCLES,
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [rrmbc_pkg::ADDR_W-1:0] bus_addr,
    input wire logic mem_read_n,
    input wire logic mem_write_n,
    input wire logic byte_high_en_n,
    input wire logic [DATA_W-1:0] bus_data_in,
    output logic [DATA_W-1:0] bus_data_out,
    output logic bus_data_oe,
    output logic bus_ack_out_n,
    output logic [rrmbc_pkg::RA_W-1:0] dram_addr,
    output logic dram_ras_n,
    output logic dram_cas_n,
    output logic write_en_low_byte_n,
    output logic write_en_high_byte_n,
    output logic early_ack_n,
    output logic xfer_ack_n,
    output logic ram_write_buf_en_n,
    output logic [DATA_W-1:0] ram_write_data,
    input wire logic [DATA_W-1:0] array_read_data,
    output logic array_addr_hit_n,
    output logic data_out_drive_n,
    input wire logic [DATA_W-1:0] rom_data,
    input wire logic rom_output_inhibit,
    output logic [rrmbc_pkg::BANKS-1:0] rom_bank_sel_n,
    output logic [rrmbc_pkg::WORD_W-1:0] rom_word_addr,
    output logic rom_read_active_n,
    output logic driver_gate_n
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] rd_sync;
        logic [2:0] wr_sync;
        logic rd_cmd_n;
        logic wr_cmd_n;
        logic [rrmbc_pkg::ACC_W-1:0] acc;
        logic tick;
        logic [rrmbc_pkg::REF_W-1:0] ref_timer;
        logic ref_pend;
        logic [rrmbc_pkg::RA_W-1:0] ref_ctr;
        rrmbc_pkg::rrmbc_state_t state;
        logic is_write;
        logic [rrmbc_pkg::RA_W-1:0] ra;
        logic rom_drv;
        logic [DATA_W-1:0] out_data;
    } rrmbc_regs_t;

    localparam logic [rrmbc_pkg::ACC_W-1:0] CTRL_INC =
        rrmbc_pkg::ACC_W'(rrmbc_pkg::CTRL_KHZ);
    localparam logic [rrmbc_pkg::ACC_W-1:0] CLK_MOD =
        rrmbc_pkg::ACC_W'(rrmbc_pkg::CLK_KHZ);
    localparam logic [rrmbc_pkg::REF_W-1:0] REF_LAST =
        rrmbc_pkg::REF_W'(REFRESH_CYC - 1);

    rrmbc_regs_t s_reg;
    rrmbc_regs_t s_next;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // true in every step of a ram access, refresh excluded
    function automatic logic in_access(rrmbc_pkg::rrmbc_state_t st);
        in_access = (st != rrmbc_pkg::ST_IDLE) &&
            (st != rrmbc_pkg::ST_REF);
    endfunction

    // true once the named step has been reached in an access
    function automatic logic from_step(rrmbc_pkg::rrmbc_state_t st,
        rrmbc_pkg::rrmbc_state_t first);
        case (first)
            rrmbc_pkg::ST_RAS:
                from_step = in_access(st) && (st != rrmbc_pkg::ST_ROW);
            rrmbc_pkg::ST_WE:
                from_step = (st == rrmbc_pkg::ST_WE) ||
                    (st == rrmbc_pkg::ST_CAS) ||
                    (st == rrmbc_pkg::ST_XACK);
            rrmbc_pkg::ST_CAS:
                from_step = (st == rrmbc_pkg::ST_CAS) ||
                    (st == rrmbc_pkg::ST_XACK);
            default:
                from_step = in_access(st);
        endcase
    endfunction

    // a command level counts only once sync stages two and three agree,
    // so a pin moving near the clock edge cannot start half a cycle
    function automatic logic settle(logic [2:0] stages, logic held);
        if (stages[1] == stages[2]) begin
            settle = stages[2];
        end else begin
            settle = held;
        end
    endfunction

    logic [4:0] sel_bits;
    logic ram_hit;
    logic rd_req;
    logic wr_req;
    logic dec_en_a_n;
    logic dec_en_b_n;
    logic rom_dec_on;
    logic rom_win;
    logic rom_rd;
    logic [rrmbc_pkg::BANK_W-1:0] bank;
    logic [rrmbc_pkg::ACC_W-1:0] acc_sum;
    logic we_on;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign sel_bits = bus_addr[rrmbc_pkg::SEL_MSB:rrmbc_pkg::SEL_LSB];
    assign ram_hit = (sel_bits == rrmbc_pkg::RAM_SEL);
    assign array_addr_hit_n = ~ram_hit;
    // the address is held stable by the master before any command
    assign rd_req = ~s_reg.rd_cmd_n & ram_hit;
    assign wr_req = ~s_reg.wr_cmd_n & ram_hit;

    // ----------------------------------------------------------------
    // rom bank decode
    // ----------------------------------------------------------------
    assign dec_en_b_n = s_reg.rd_cmd_n;
    assign dec_en_a_n = ~((sel_bits == rrmbc_pkg::ROM_SEL_A) ||
        (sel_bits == rrmbc_pkg::ROM_SEL_B));
    assign rom_dec_on = ~dec_en_a_n & ~dec_en_b_n;
    assign bank = bus_addr[rrmbc_pkg::BANK_LSB +: rrmbc_pkg::BANK_W];

    // eight banks of two byte devices, 4K words each
    genvar gi;
    generate
        for (gi = 0; gi < rrmbc_pkg::BANKS; gi++) begin : g_bank
            assign rom_bank_sel_n[gi] =
                ~(rom_dec_on && (bank == rrmbc_pkg::BANK_W'(gi)));
        end
    endgenerate

    // ----------------------------------------------------------------
    // rom window and word
    // ----------------------------------------------------------------
    assign rom_word_addr =
        bus_addr[rrmbc_pkg::WORD_LSB +: rrmbc_pkg::WORD_W];
    assign rom_win = (bus_addr >= rrmbc_pkg::ROM_LO) &&
        (bus_addr <= rrmbc_pkg::ROM_HI);
    assign rom_rd = ~s_reg.rd_cmd_n & rom_win;
    assign rom_read_active_n = ~rom_rd;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;

        // ------------------------------------------------------------
        // command synchronisers
        // ------------------------------------------------------------
        // three stages; a change counts once stages two and three agree
        s_next.rd_sync = {s_reg.rd_sync[1:0], mem_read_n};
        s_next.wr_sync = {s_reg.wr_sync[1:0], mem_write_n};
        s_next.rd_cmd_n = settle(s_reg.rd_sync, s_reg.rd_cmd_n);
        s_next.wr_cmd_n = settle(s_reg.wr_sync, s_reg.wr_cmd_n);

        // ------------------------------------------------------------
        // controller rate
        // ------------------------------------------------------------
        // fractional divider gives the controller rate on average;
        // single ticks jitter by one system clock, which is harmless
        acc_sum = s_reg.acc + CTRL_INC;
        if (acc_sum >= CLK_MOD) begin
            s_next.acc = acc_sum - CLK_MOD;
            s_next.tick = 1'b1;
        end else begin
            s_next.acc = acc_sum;
            s_next.tick = 1'b0;
        end

        // ------------------------------------------------------------
        // access and refresh sequence
        // ------------------------------------------------------------
        if (s_reg.tick) begin
            case (s_reg.state)
                rrmbc_pkg::ST_IDLE: begin
                    if (rd_req || wr_req) begin
                        s_next.state = rrmbc_pkg::ST_ROW;
                        s_next.is_write = wr_req & ~rd_req;
                        s_next.ra = bus_addr[rrmbc_pkg::ROW_LSB +:
                            rrmbc_pkg::RA_W];
                    end else if (s_reg.ref_pend) begin
                        s_next.state = rrmbc_pkg::ST_REF;
                        s_next.ra = s_reg.ref_ctr;
                        s_next.ref_pend = 1'b0;
                    end
                end
                rrmbc_pkg::ST_ROW: begin
                    s_next.state = rrmbc_pkg::ST_RAS;
                end
                rrmbc_pkg::ST_RAS: begin
                    s_next.state = rrmbc_pkg::ST_COL;
                    s_next.ra = bus_addr[rrmbc_pkg::COL_LSB +:
                        rrmbc_pkg::RA_W];
                end
                rrmbc_pkg::ST_COL: begin
                    s_next.state = rrmbc_pkg::ST_WE;
                end
                rrmbc_pkg::ST_WE: begin
                    s_next.state = rrmbc_pkg::ST_CAS;
                end
                rrmbc_pkg::ST_CAS: begin
                    s_next.state = rrmbc_pkg::ST_XACK;
                    s_next.out_data = array_read_data;
                end
                rrmbc_pkg::ST_XACK: begin
                    // held until the master drops its command, so a
                    // long command cannot start a second cycle
                    if (s_reg.is_write ? s_reg.wr_cmd_n
                            : s_reg.rd_cmd_n) begin
                        s_next.state = rrmbc_pkg::ST_IDLE;
                    end
                end
                rrmbc_pkg::ST_REF: begin
                    // one tick of ras per row; the counter then moves on
                    s_next.state = rrmbc_pkg::ST_IDLE;
                    s_next.ref_ctr = s_reg.ref_ctr +
                        rrmbc_pkg::RA_W'(1);
                end
                default: begin
                    s_next.state = rrmbc_pkg::ST_IDLE;
                end
            endcase
        end

        // ------------------------------------------------------------
        // refresh timer
        // ------------------------------------------------------------
        // timer set comes after the clear above, so a set wins
        if (s_reg.ref_timer == REF_LAST) begin
            s_next.ref_timer = '0;
            s_next.ref_pend = 1'b1;
        end else begin
            s_next.ref_timer = s_reg.ref_timer +
                rrmbc_pkg::REF_W'(1);
        end

        // ------------------------------------------------------------
        // rom data path
        // ------------------------------------------------------------
        // rom data is registered with its gate so both move together;
        // inhibit is a board level on this clock, so it is not synced
        s_next.rom_drv = rom_rd & rom_output_inhibit;
        if (rom_rd) begin
            s_next.out_data = rom_data;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            // commands leave reset released, so no false start follows
            s_reg.rd_sync <= 3'h7;
            s_reg.wr_sync <= 3'h7;
            s_reg.rd_cmd_n <= 1'b1;
            s_reg.wr_cmd_n <= 1'b1;
            s_reg.state <= rrmbc_pkg::ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // dram strobes and acknowledges
    // ----------------------------------------------------------------
    assign dram_addr = s_reg.ra;
    assign early_ack_n = ~in_access(s_reg.state);
    assign dram_ras_n = ~(from_step(s_reg.state, rrmbc_pkg::ST_RAS) ||
        (s_reg.state == rrmbc_pkg::ST_REF));
    assign dram_cas_n = ~from_step(s_reg.state, rrmbc_pkg::ST_CAS);

    // ----------------------------------------------------------------
    // byte write enables
    // ----------------------------------------------------------------
    assign we_on = from_step(s_reg.state, rrmbc_pkg::ST_WE) &
        s_reg.is_write;
    assign write_en_low_byte_n =
        ~(we_on & ~bus_addr[rrmbc_pkg::BYTE_BIT]);
    assign write_en_high_byte_n = ~(we_on & ~byte_high_en_n);
    assign xfer_ack_n = ~(s_reg.state == rrmbc_pkg::ST_XACK);

    // ----------------------------------------------------------------
    // write data buffer
    // ----------------------------------------------------------------
    assign ram_write_buf_en_n = s_reg.wr_cmd_n | ~ram_hit;
    // plain buffer, no register: the array takes it while cas is low
    assign ram_write_data = bus_data_in;

    // ----------------------------------------------------------------
    // bus acknowledge
    // ----------------------------------------------------------------
    // ack leads data by the early-ack to xack steps
    assign bus_ack_out_n = early_ack_n & rom_read_active_n;

    // ----------------------------------------------------------------
    // data to the bus
    // ----------------------------------------------------------------
    // drive stops as soon as the master drops its read command
    assign data_out_drive_n = ~(~xfer_ack_n & ~s_reg.is_write &
        ~s_reg.rd_cmd_n);
    assign driver_gate_n = ~s_reg.rom_drv;
    assign bus_data_out = s_reg.out_data;
    assign bus_data_oe = ~data_out_drive_n | ~driver_gate_n;

endmodule

// ---- verif/rrmbc_ctrl_asserts.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checks of the controller
// ----------------------------------------------------------------
module rrmbc_ctrl_asserts #(
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic mem_read_n,
    input wire logic mem_write_n,
    input wire logic [19:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_data_out,
    input wire logic bus_data_oe,
    input wire logic bus_ack_out_n,
    input wire logic [6:0] dram_addr,
    input wire logic dram_ras_n,
    input wire logic dram_cas_n,
    input wire logic write_en_low_byte_n,
    input wire logic write_en_high_byte_n,
    input wire logic early_ack_n,
    input wire logic xfer_ack_n,
    input wire logic [DATA_W-1:0] array_read_data,
    input wire logic array_addr_hit_n,
    input wire logic data_out_drive_n,
    input wire logic [DATA_W-1:0] rom_data,
    input wire logic rom_output_inhibit,
    input wire logic [7:0] rom_bank_sel_n,
    input wire logic rom_read_active_n,
    input wire logic driver_gate_n
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence access_start;
        $fell(early_ack_n) && dram_ras_n;
    endsequence
    sequence we_start;
        $fell(write_en_low_byte_n) || $fell(write_en_high_byte_n);
    endsequence
    sequence ras_refresh;
        $fell(dram_ras_n) && early_ack_n;
    endsequence
    // one controller tick is four or five system clocks
    row_then_ras_a: assert property (access_start |->
        dram_addr == bus_addr[7:1] ##[1:6] $fell(dram_ras_n))
        else $error("row address or ras step wrong");
    col_addr_a: assert property ($fell(dram_cas_n) |->
        !early_ack_n && dram_addr == bus_addr[14:8])
        else $error("column address wrong at cas");
    we_then_cas_a: assert property (we_start |->
        dram_cas_n ##[1:6] $fell(dram_cas_n))
        else $error("cas did not follow write enable");
    read_no_we_a: assert property ((!data_out_drive_n ||
        (!early_ack_n && !mem_read_n && mem_write_n)) |->
        write_en_low_byte_n && write_en_high_byte_n)
        else $error("write enable during a read");
    xack_latch_a: assert property ($fell(xfer_ack_n) |->
        !dram_cas_n && bus_data_out == $past(array_read_data))
        else $error("read data not latched at xack");
    read_drive_a: assert property (!data_out_drive_n |->
        !xfer_ack_n && !bus_ack_out_n && bus_data_oe)
        else $error("bus driven without acknowledge");
    refresh_ras_a: assert property (ras_refresh |->
        dram_cas_n && xfer_ack_n ##[1:6] $rose(dram_ras_n))
        else $error("refresh cycle malformed");
    ram_decode_a: assert property (
        (bus_addr[19:15] == 5'h00) == !array_addr_hit_n)
        else $error("ram decode wrong");
    rom_bank_a: assert property (!rom_read_active_n |->
        bus_addr >= 20'hE8000 && bus_addr <= 20'hF7FFF &&
        rom_bank_sel_n == ~(8'h01 << bus_addr[15:13]))
        else $error("rom window or bank select wrong");
    rom_ack_a: assert property (!rom_read_active_n |-> !bus_ack_out_n)
        else $error("rom read without bus acknowledge");
    rom_gate_a: assert property (!driver_gate_n |->
        $past(rom_output_inhibit) && !$past(rom_read_active_n) &&
        bus_data_out == $past(rom_data))
        else $error("rom drivers gated wrongly");
endmodule
bind rrmbc_ctrl rrmbc_ctrl_asserts #(.DATA_W(DATA_W)) i_chk (
    .sys_clk, .rst, .mem_read_n, .mem_write_n,
    .bus_addr, .bus_data_out, .bus_data_oe,
    .bus_ack_out_n, .dram_addr, .dram_ras_n, .dram_cas_n,
    .write_en_low_byte_n, .write_en_high_byte_n, .early_ack_n,
    .xfer_ack_n, .array_read_data, .array_addr_hit_n,
    .data_out_drive_n, .rom_data, .rom_output_inhibit,
    .rom_bank_sel_n, .rom_read_active_n, .driver_gate_n
);

// ---- verif/rrmbc_mem_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// dram array and rom banks behind the controller
// ----------------------------------------------------------------
module rrmbc_mem_model (
    input wire logic sys_clk,
    input wire logic [6:0] dram_addr,
    input wire logic dram_ras_n,
    input wire logic dram_cas_n,
    input wire logic write_en_low_byte_n,
    input wire logic write_en_high_byte_n,
    input wire logic [15:0] ram_write_data,
    input wire logic [7:0] rom_bank_sel_n,
    input wire logic [11:0] rom_word_addr,
    output logic [15:0] array_read_data,
    output logic [15:0] rom_data
);
    logic [15:0] mem [0:16383];
    logic [6:0] row;
    logic [6:0] col;
    logic [2:0] bank;
    logic hit;
    // strobes are sampled on the clock to avoid racing the address
    always @(posedge sys_clk) begin
        if (dram_ras_n)
            row <= dram_addr;
        if (dram_cas_n)
            col <= dram_addr;
        if (!dram_cas_n && !write_en_low_byte_n)
            mem[{col, row}][7:0] <= ram_write_data[7:0];
        if (!dram_cas_n && !write_en_high_byte_n)
            mem[{col, row}][15:8] <= ram_write_data[15:8];
    end
    // outputs off: a changing pattern, never the last value
    assign array_read_data = dram_cas_n ? {16{sys_clk}} ^ 16'h5A5A
        : mem[{col, row}];
    always_comb begin
        bank = 3'h0;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (!rom_bank_sel_n[i]) begin
                bank = i[2:0];
                hit = 1'b1;
            end
        end
    end
    assign rom_data = hit ? {1'b0, bank, rom_word_addr}
        : {16{sys_clk}} ^ 16'hC3C3;
endmodule

// ---- verif/tb_ram_rom_memory_board_ctrl.sv ----
`timescale 1ns/1ps
module tb_ram_rom_memory_board_ctrl;
    logic sys_clk, rst, mem_read_n, mem_write_n, byte_high_en_n;
    logic bus_data_oe, bus_ack_out_n, dram_ras_n, dram_cas_n;
    logic write_en_low_byte_n, write_en_high_byte_n, early_ack_n;
    logic xfer_ack_n, ram_write_buf_en_n, array_addr_hit_n;
    logic data_out_drive_n, rom_output_inhibit, rom_read_active_n;
    logic driver_gate_n;
    logic [19:0] bus_addr;
    logic [15:0] bus_data_in, bus_data_out, ram_write_data, q;
    logic [15:0] array_read_data, rom_data;
    logic [6:0] dram_addr;
    logic [7:0] rom_bank_sel_n;
    logic [11:0] rom_word_addr;
    int fails = 0;
    int n_compared = 0;
    // short refresh interval keeps the run brief
    rrmbc_ctrl #(.REFRESH_CYC(50)) i_dut (
        .sys_clk, .rst, .bus_addr, .mem_read_n, .mem_write_n,
        .byte_high_en_n, .bus_data_in, .bus_data_out, .bus_data_oe,
        .bus_ack_out_n, .dram_addr, .dram_ras_n, .dram_cas_n,
        .write_en_low_byte_n, .write_en_high_byte_n, .early_ack_n,
        .xfer_ack_n, .ram_write_buf_en_n, .ram_write_data,
        .array_read_data, .array_addr_hit_n, .data_out_drive_n,
        .rom_data, .rom_output_inhibit, .rom_bank_sel_n,
        .rom_word_addr, .rom_read_active_n, .driver_gate_n
    );
    rrmbc_mem_model i_mem (
        .sys_clk, .dram_addr, .dram_ras_n, .dram_cas_n,
        .write_en_low_byte_n, .write_en_high_byte_n, .ram_write_data,
        .rom_bank_sel_n, .rom_word_addr, .array_read_data, .rom_data
    );
    always #5 sys_clk = ~sys_clk;
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_for(ref logic sig, input logic val);
        repeat (300) if (sig !== val) @(negedge sys_clk);
    endtask
    task automatic access(input logic wr, input logic [19:0] a,
        input logic hi_n, input logic [15:0] d);
        @(negedge sys_clk);
        bus_addr = a;
        byte_high_en_n = hi_n;
        bus_data_in = d;
        mem_write_n = !wr;
        mem_read_n = wr;
        wait_for(xfer_ack_n, 1'b0);
        check(xfer_ack_n, 1'b0);
        check(bus_ack_out_n, 1'b0);
        q = bus_data_out;
        if (wr)
            check(ram_write_buf_en_n, 1'b0);
        else
            check(data_out_drive_n, 1'b0);
        mem_write_n = 1'b1;
        mem_read_n = 1'b1;
        wait_for(early_ack_n, 1'b1);
        check(dram_ras_n, 1'b1);
        check(bus_data_oe, 1'b0);
    endtask
    task automatic t_ram;
        access(1'b1, 20'h00002, 1'b0, 16'h1234);
        access(1'b1, 20'h07FFE, 1'b0, 16'hABCD);
        access(1'b1, 20'h00003, 1'b0, 16'hEE00);
        access(1'b1, 20'h07FFE, 1'b1, 16'h00FF);
        access(1'b0, 20'h00002, 1'b1, 16'h0000);
        check(q, 16'hEE34);
        access(1'b0, 20'h07FFE, 1'b1, 16'h0000);
        check(q, 16'hABFF);
        check(array_addr_hit_n, 1'b0);
        $display("test ram done");
    endtask
    task automatic t_miss(input logic [19:0] a);
        @(negedge sys_clk);
        bus_addr = a;
        mem_read_n = 1'b0;
        repeat (40) @(negedge sys_clk);
        check(early_ack_n, 1'b1);
        check(rom_read_active_n, 1'b1);
        check(rom_bank_sel_n, 8'hFF);
        mem_read_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        $display("test miss done");
    endtask
    task automatic t_rom;
        logic [19:0] a;
        logic [7:0] sel;
        for (int k = 0; k < 8; k++) begin
            a = 20'hE8000 + 20'h2000 * k + 20'h492 * k;
            sel = ~(8'h01 << a[15:13]);
            @(negedge sys_clk);
            bus_addr = a;
            mem_read_n = 1'b0;
            wait_for(driver_gate_n, 1'b0);
            check(rom_bank_sel_n, sel);
            check(bus_data_oe, 1'b1);
            check(bus_ack_out_n, 1'b0);
            check(bus_data_out, {1'b0, a[15:13], a[12:1]});
            mem_read_n = 1'b1;
            wait_for(rom_read_active_n, 1'b1);
            repeat (2) @(negedge sys_clk);
            check(driver_gate_n, 1'b1);
        end
        rom_output_inhibit = 1'b0;
        bus_addr = 20'hF0000;
        mem_read_n = 1'b0;
        wait_for(rom_read_active_n, 1'b0);
        repeat (3) @(negedge sys_clk);
        check(driver_gate_n, 1'b1);
        check(bus_data_oe, 1'b0);
        check(bus_ack_out_n, 1'b0);
        mem_read_n = 1'b1;
        wait_for(rom_read_active_n, 1'b1);
        rom_output_inhibit = 1'b1;
        $display("test rom done");
    endtask
    task automatic t_ref;
        logic [6:0] r0;
        int n;
        wait_for(dram_ras_n, 1'b0);
        check(early_ack_n, 1'b1);
        r0 = dram_addr;
        wait_for(dram_ras_n, 1'b1);
        n = 0;
        while (dram_ras_n !== 1'b0 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        r0 = r0 + 7'h01;
        check(dram_addr, r0);
        check(n < 60, 1'b1);
        access(1'b0, 20'h00002, 1'b1, 16'h0000);
        check(q, 16'hEE34);
        $display("test refresh done");
    endtask
    task automatic t_reset;
        @(negedge sys_clk);
        bus_addr = 20'h00002;
        mem_read_n = 1'b0;
        wait_for(early_ack_n, 1'b0);
        rst = 1'b1;
        mem_read_n = 1'b1;
        @(negedge sys_clk);
        check(early_ack_n, 1'b1);
        check(dram_ras_n, 1'b1);
        check(bus_ack_out_n, 1'b1);
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(early_ack_n, 1'b1);
        access(1'b0, 20'h00002, 1'b1, 16'h0000);
        check(q, 16'hEE34);
        $display("test reset done");
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        mem_read_n = 1'b1;
        mem_write_n = 1'b1;
        byte_high_en_n = 1'b1;
        bus_addr = 20'h00000;
        bus_data_in = 16'h0000;
        rom_output_inhibit = 1'b1;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        t_ram();
        t_miss(20'h08000);
        t_miss(20'hE7FFE);
        t_miss(20'hF8000);
        t_rom();
        t_ref();
        t_reset();
        give_verdict();
    end
    initial begin
        #500000;
        fails++;
        give_verdict();
    end
endmodule
